// ### vadc_pkg.sv
// Package for the voltage converter control block: register map, fields,
// reset values and timing counts.
// Assumes a 50 MHz system clock and byte-wide registers on word addresses.
package vadc_pkg;
    // Register byte addresses on the bus (word aligned)
    localparam logic [3:0] OFS_CHANNEL_SELECT  = 4'h0;
    localparam logic [3:0] OFS_CONTROL_STATUS  = 4'h4;
    localparam logic [3:0] OFS_RESULT_LOW      = 4'h8;
    localparam logic [3:0] OFS_RESULT_HIGH     = 4'hC;
    localparam logic [4:0] OFS_PIN_DISABLE     = 5'h10;
    // Control and status field positions
    localparam int BIT_CONVERTER_ENABLE        = 3;
    localparam int BIT_CONVERT_START           = 2;
    localparam int BIT_DONE_FLAG               = 1;
    localparam int BIT_DONE_IRQ_ENABLE         = 0;
    // Reset values
    localparam logic [3:0] RST_CONTROL_STATUS  = 4'h0;
    localparam logic [3:0] RST_CHANNEL_SELECT  = 4'h0;
    localparam logic [3:0] RST_PIN_DISABLE     = 4'h0;
    localparam logic [11:0] RST_RESULT         = 12'h000;
    // Valid channel code range
    localparam logic [3:0] CHAN_FIRST          = 4'h1;
    localparam logic [3:0] CHAN_LAST           = 4'hA;
    // Conversion time
    localparam int CLK_HZ                      = 50_000_000;
    localparam int CONV_TIME_US                = 519;
    localparam int CONV_CYCLES =
        (CONV_TIME_US * (CLK_HZ / 1_000_000));
    localparam int RESULT_W                    = 12;
endpackage

// ### voltage_adc_control.sv
// Control logic of the 12-bit voltage converter: registers, start/busy,
// fixed conversion timer, completion flag and interrupt request.
// Assumes an Avalon-MM master on CLK_SYS; modulator result and sleep state
// arrive on the same clock; pin levels arrive asynchronously.
//
// Behaviour
// - Clearing converter enable turns converter off and aborts running conversion.
// - Power-down or power-off sleep disables the converter automatically.
// - Writing one to convert start begins conversion of the selected channel.
// - Convert start reads one while converting, hardware clears it at completion.
// - Writing zero to convert start has no effect.
// - Convert start clears whenever converter enable is written zero.
// - Channel change during conversion applies only after that conversion.
// - A conversion takes 519 us from start to completion flag.
// - Completion flag sets in the same step the result registers update.
// - Interrupt requested only when flag, enable and global enable all set.
// - Flag clears when processor enters the matching interrupt vector.
// - Writing one to the flag clears it, zero leaves it.
// - Channel codes 1 to 10 select cells, ADC4, temperature, ADC0 to ADC3.
// - Upper four bits of channel select and control status read zero.
// - The 12-bit result is presented across low and high result bytes.
// - Pin disable bit turns off input buffer, port bit reads zero.
`timescale 1ns/1ps
module voltage_adc_control #(
    parameter int CONV_COUNT = vadc_pkg::CONV_CYCLES
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        SLEEP_DEEP,
    input  wire logic        GLOBAL_IRQ_ENABLE,
    input  wire logic        IRQ_VECTOR_ACK,
    input  wire logic [11:0] MODULATOR_RESULT,
    input  wire logic [3:0]  ANALOG_PIN_LEVEL,
    output logic             CONVERTER_POWER,
    output logic [3:0]       ACTIVE_CHANNEL,
    output logic             CHANNEL_VALID,
    output logic             CONVERT_DONE_IRQ,
    output logic [3:0]       PIN_INPUT_BUFFER_OFF,
    output logic [3:0]       PORT_INPUT
);

    typedef enum logic [1:0] {
        IDLE,
        CONVERT
    } conv_state_t;

    typedef struct packed {
        conv_state_t  state;
        logic [31:0]  timer;
        logic [3:0]   channel_select;
        logic [3:0]   active_channel;
        logic         converter_enable;
        logic         convert_start;
        logic         convert_done_flag;
        logic         convert_done_irq_enable;
        logic [11:0]  result;
        logic [3:0]   pin_disable;
        logic [3:0]   pin_sync1;
        logic [3:0]   pin_sync2;
        logic [3:0]   port_input;
        logic         irq;
        logic         power;
        logic         chan_valid;
        logic         ack;
        logic         waitreq;
        logic [31:0]  rdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] wbyte;

    // Single-cycle wait: request is answered the edge after it is seen
    assign wr_hit = AVS_WRITE && !cur.ack && AVS_BYTEENABLE[0];
    assign rd_hit = AVS_READ && !cur.ack;
    assign wbyte  = AVS_WRITEDATA[7:0];

    // Next-state computation for the whole block
    always_comb begin
        logic       en_now;
        logic       done_now;
        en_now   = 1'b0;
        done_now = 1'b0;
        next_cur = cur;
        next_cur.ack = (AVS_READ || AVS_WRITE) && !cur.ack;
        // Registered copy so the bus output needs no inverter after the flop
        next_cur.waitreq = !next_cur.ack;

        // Software writes
        if (wr_hit) begin
            unique case (AVS_ADDRESS)
                {1'b0, vadc_pkg::OFS_CHANNEL_SELECT}: begin
                    next_cur.channel_select = wbyte[3:0];
                end
                {1'b0, vadc_pkg::OFS_CONTROL_STATUS}: begin
                    next_cur.converter_enable =
                        wbyte[vadc_pkg::BIT_CONVERTER_ENABLE];
                    next_cur.convert_done_irq_enable =
                        wbyte[vadc_pkg::BIT_DONE_IRQ_ENABLE];
                    if (wbyte[vadc_pkg::BIT_DONE_FLAG]) begin
                        next_cur.convert_done_flag = 1'b0;
                    end
                end
                vadc_pkg::OFS_PIN_DISABLE: begin
                    next_cur.pin_disable = wbyte[3:0];
                end
                default: begin
                end
            endcase
        end

        // Vector entry clears the flag as well
        if (IRQ_VECTOR_ACK) begin
            next_cur.convert_done_flag = 1'b0;
        end

        en_now = next_cur.converter_enable && !SLEEP_DEEP;

        // Conversion sequencing
        unique case (cur.state)
            IDLE: begin
                if (wr_hit && AVS_ADDRESS ==
                        {1'b0, vadc_pkg::OFS_CONTROL_STATUS}
                        && wbyte[vadc_pkg::BIT_CONVERT_START]
                        && en_now) begin
                    next_cur.state          = CONVERT;
                    next_cur.convert_start  = 1'b1;
                    next_cur.timer          = 32'h0000_0001;
                    next_cur.active_channel = next_cur.channel_select;
                end
            end
            CONVERT: begin
                if (!en_now) begin
                    // Abort: disable or deep sleep stops everything
                    next_cur.state         = IDLE;
                    next_cur.convert_start = 1'b0;
                end else if (cur.timer >= 32'(CONV_COUNT)) begin
                    next_cur.state         = IDLE;
                    next_cur.convert_start = 1'b0;
                    done_now               = 1'b1;
                end else begin
                    next_cur.timer = cur.timer + 32'h0000_0001;
                end
            end
            default: begin
                next_cur.state = IDLE;
            end
        endcase

        // Result and flag in one step; set wins over any clear
        if (done_now) begin
            next_cur.result            = MODULATOR_RESULT;
            next_cur.convert_done_flag = 1'b1;
        end

        // Idle channel follows the selection once no conversion runs
        if (next_cur.state == IDLE) begin
            next_cur.active_channel = next_cur.channel_select;
        end

        next_cur.power      = en_now;
        next_cur.chan_valid = (next_cur.active_channel
                                   >= vadc_pkg::CHAN_FIRST)
                              && (next_cur.active_channel
                                   <= vadc_pkg::CHAN_LAST);
        next_cur.irq = next_cur.convert_done_flag
                       && next_cur.convert_done_irq_enable
                       && GLOBAL_IRQ_ENABLE;

        // Pin levels pass two flops, then the disable mask
        next_cur.pin_sync1  = ANALOG_PIN_LEVEL;
        next_cur.pin_sync2  = cur.pin_sync1;
        next_cur.port_input = cur.pin_sync2 & ~cur.pin_disable;

        // Read data, reserved bits zero
        next_cur.rdata = 32'h0000_0000;
        if (rd_hit) begin
            unique case (AVS_ADDRESS)
                {1'b0, vadc_pkg::OFS_CHANNEL_SELECT}:
                    next_cur.rdata[3:0] = cur.channel_select;
                {1'b0, vadc_pkg::OFS_CONTROL_STATUS}:
                    next_cur.rdata[3:0] = {cur.converter_enable,
                        cur.convert_start, cur.convert_done_flag,
                        cur.convert_done_irq_enable};
                {1'b0, vadc_pkg::OFS_RESULT_LOW}:
                    next_cur.rdata[7:0] = cur.result[7:0];
                {1'b0, vadc_pkg::OFS_RESULT_HIGH}:
                    next_cur.rdata[3:0] = cur.result[11:8];
                vadc_pkg::OFS_PIN_DISABLE:
                    next_cur.rdata[3:0] = cur.pin_disable;
                default:
                    next_cur.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cur <= '0;
            cur.state <= IDLE;
            cur.waitreq <= 1'b1;
            cur.channel_select <= vadc_pkg::RST_CHANNEL_SELECT;
            cur.active_channel <= vadc_pkg::RST_CHANNEL_SELECT;
            cur.pin_disable <= vadc_pkg::RST_PIN_DISABLE;
            cur.result <= vadc_pkg::RST_RESULT;
            {cur.converter_enable, cur.convert_start,
             cur.convert_done_flag, cur.convert_done_irq_enable}
                <= vadc_pkg::RST_CONTROL_STATUS;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from flops; waitrequest low only in the answer cycle
    assign AVS_READDATA         = cur.rdata;
    assign AVS_WAITREQUEST      = cur.waitreq;
    assign CONVERTER_POWER      = cur.power;
    assign ACTIVE_CHANNEL       = cur.active_channel;
    assign CHANNEL_VALID        = cur.chan_valid;
    assign CONVERT_DONE_IRQ     = cur.irq;
    assign PIN_INPUT_BUFFER_OFF = cur.pin_disable;
    assign PORT_INPUT           = cur.port_input;

endmodule

// ### voltage_adc_control_props.sv
// Checker for the voltage converter control block, on top-level ports.
// Assumes one clock domain and single-cycle bus answers.
`timescale 1ns/1ps
module voltage_adc_control_props (
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic [4:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        SLEEP_DEEP,
    input wire logic        GLOBAL_IRQ_ENABLE,
    input wire logic        CONVERTER_POWER,
    input wire logic        CONVERT_DONE_IRQ,
    input wire logic [3:0]  PIN_INPUT_BUFFER_OFF,
    input wire logic [3:0]  PORT_INPUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // A write the slave accepts at this edge
    wire take = AVS_WRITE & AVS_WAITREQUEST & AVS_BYTEENABLE[0];
    a_wait_answer: assert property ((AVS_READ | AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("request not answered");
    a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("answer held too long");
    a_rdata_idle: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0)
        else $error("read data not zero");
    a_reserved_zero: assert property (!AVS_WAITREQUEST && AVS_READ &&
        AVS_ADDRESS inside {5'h00, 5'h04} |-> AVS_READDATA[31:4] == 28'h0)
        else $error("upper bits not zero");
    a_irq_gate: assert property (CONVERT_DONE_IRQ |->
        $past(GLOBAL_IRQ_ENABLE)) else $error("irq without global enable");
    a_sleep_off: assert property (SLEEP_DEEP |=> !CONVERTER_POWER)
        else $error("powered in deep sleep");
    a_disable_off: assert property (take && AVS_ADDRESS == 5'h04 &&
        !AVS_WRITEDATA[3] |-> ##3 !CONVERTER_POWER)
        else $error("powered after disable");
    // Mask applied from the disable bits held over two edges
    a_port_mask: assert property ((PORT_INPUT & PIN_INPUT_BUFFER_OFF &
        $past(PIN_INPUT_BUFFER_OFF)) == 4'h0) else $error("pin not masked");
endmodule
bind voltage_adc_control voltage_adc_control_props u_props (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .SLEEP_DEEP(SLEEP_DEEP), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
    .CONVERTER_POWER(CONVERTER_POWER), .CONVERT_DONE_IRQ(CONVERT_DONE_IRQ),
    .PIN_INPUT_BUFFER_OFF(PIN_INPUT_BUFFER_OFF), .PORT_INPUT(PORT_INPUT));

// ### voltage_adc_control_bench.sv
// Self-checking bench for the voltage converter control block.
// Drives bus and side inputs directly; conversion count shortened to 20.
`timescale 1ns/1ps
module voltage_adc_control_bench;
    localparam int CC = 20;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'h1;
    logic [31:0] rdat;
    logic        wt;
    logic        slp = 1'b0;
    logic        gie = 1'b0;
    logic        ack = 1'b0;
    logic [11:0] mres = 12'h000;
    logic [3:0]  pin = 4'h0;
    logic        pwr;
    logic [3:0]  chan;
    logic        cval;
    logic        irq;
    logic [3:0]  boff;
    logic [3:0]  pin_in;
    logic [7:0]  q;
    logic [3:0]  r;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 32'h6e65;
    voltage_adc_control #(.CONV_COUNT(CC)) u_voltage_adc_control (
        .CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt), .SLEEP_DEEP(slp),
        .GLOBAL_IRQ_ENABLE(gie), .IRQ_VECTOR_ACK(ack),
        .MODULATOR_RESULT(mres), .ANALOG_PIN_LEVEL(pin),
        .CONVERTER_POWER(pwr), .ACTIVE_CHANNEL(chan), .CHANNEL_VALID(cval),
        .CONVERT_DONE_IRQ(irq), .PIN_INPUT_BUFFER_OFF(boff),
        .PORT_INPUT(pin_in));
    initial forever #10 clk = ~clk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] s, e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One bus cycle; waitrequest and read data sampled at the rising edge
    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= {24'h0, d};
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wt !== 1'b0) begin
            n++;
            if (n > 50) begin
                n_fail++;
                report_and_stop();
            end
            @(posedge clk);
        end
        // Answer edge: take data and release here, then let one edge pass
        q = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string nm, input logic [4:0] a,
                        input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(nm, {4'h0, q}, {4'h0, e});
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) rchk("rst", 5'(i * 4), 8'h00);
        $display("reset done");
        for (int c = 0; c < 16; c++) begin
            r = 4'(c);
            xfer(1'b1, 5'h00, {4'($random(seed)), r});
            rchk("chan", 5'h00, {4'h0, r});
            chk("active", {8'h0, chan}, {8'h0, r});
            chk("valid", {11'h0, cval}, {11'h0, r >= 4'h1 && r <= 4'hA});
        end
        $display("channels done");
        mres <= 12'($random(seed));
        gie <= 1'b1;
        xfer(1'b1, 5'h00, 8'h03);
        // Bandgap reference taken as enabled by software beforehand
        xfer(1'b1, 5'h04, 8'h0D);
        xfer(1'b1, 5'h00, 8'h07);
        chk("frozen", {8'h0, chan}, 12'h003);
        repeat (CC - 10) @(posedge clk);
        rchk("busy", 5'h04, 8'h0D);
        repeat (2) @(posedge clk);
        rchk("done", 5'h04, 8'h0B);
        chk("irq", {11'h0, irq}, 12'h001);
        rchk("low", 5'h08, mres[7:0]);
        rchk("high", 5'h0C, {4'h0, mres[11:8]});
        chk("next", {8'h0, chan}, 12'h007);
        gie <= 1'b0;
        xfer(1'b1, 5'h04, 8'h09);
        chk("irq_off", {11'h0, irq}, 12'h000);
        gie <= 1'b1;
        rchk("wr0", 5'h04, 8'h0B);
        xfer(1'b1, 5'h04, 8'h0B);
        rchk("wr1", 5'h04, 8'h09);
        xfer(1'b1, 5'h04, 8'h0D);
        repeat (CC + 4) @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        rchk("vector", 5'h04, 8'h09);
        $display("conversion done");
        xfer(1'b1, 5'h04, 8'h0D);
        xfer(1'b1, 5'h04, 8'h01);
        rchk("stop", 5'h04, 8'h01);
        repeat (CC + 4) @(posedge clk);
        rchk("abort", 5'h04, 8'h01);
        chk("off", {11'h0, pwr}, 12'h000);
        xfer(1'b1, 5'h04, 8'h0D);
        slp <= 1'b1;
        repeat (CC + 4) @(posedge clk);
        chk("sleep", {11'h0, pwr}, 12'h000);
        xfer(1'b0, 5'h04, 8'h00);
        chk("sleep_flag", {11'h0, q[1]}, 12'h000);
        slp <= 1'b0;
        repeat (2) @(posedge clk);
        chk("wake", {11'h0, pwr}, 12'h001);
        $display("power done");
        for (int i = 0; i < 8; i++) begin
            r = 4'($random(seed));
            pin <= 4'($random(seed));
            xfer(1'b1, 5'h10, {4'h0, r});
            repeat (4) @(posedge clk);
            chk("pins", {8'h0, pin_in}, {8'h0, pin & ~r});
            chk("boff", {8'h0, boff}, {8'h0, r});
        end
        be <= 4'h0;
        xfer(1'b1, 5'h10, 8'h0F);
        be <= 4'h1;
        rchk("refused", 5'h10, {4'h0, r});
        xfer(1'b1, 5'h14, 8'hFF);
        rchk("unmapped", 5'h14, 8'h00);
        $display("pins done");
        report_and_stop();
    end
endmodule
